// ===== core/hbd_pkg.sv
// package: constants, register map and decay codes for the h-bridge decay drive
//
// Behaviour
// (R1) low-side fet slow decay: modulate first pair, second pos high, second neg low; when negative the code modulates the second pair instead.
// (R2) four slow decay variants choose which switches conduct while undriven.
// (R3) low-side fet recirculation is the default slow decay, for bootstrap recharge.
// (R4) shunt samples taken during slow decay carry no current and are dropped.
// (R5) fixed decay uses only the configured base decay, slow or fast.
// (R6) alternating decay switches between base decay and alternate decay.
// (R7) alternate decay only after a target drop, for a bounded number of periods.
// (R8) alternate periods per step are proportional to the target amplitude drop.
// (R9) zero target current forces fast decay against back voltage current.
// (R10) a diode slow decay may be chosen as the alternate decay.
// (R11) the two pos outputs push current positive, the two neg outputs negative.
// (R12) low-side fet slow decay: first neg complements first pos, second pos complements second neg.
// (R13) both high controls low means low switches conduct: slow recirculation.
// (R14) two converter triggers per period: mid active pulse and mid inactive pulse.
// (R15) current updates from active sample when positive, inactive sample when negative.
// (R16) duty below about 1.75 us (7% at 40 kHz) is raised to the minimum.
// (R17) energized samples are positive magnitudes, fast decay samples negative.
// (R18) fast decay sample magnitude equals the true winding current magnitude.
// (R19) fast and reverse decay selectable; fast modulates pos outputs, neg outputs held zero; when negative the code modulates neg outputs instead.
// (R20) decay, direction and duty changes are latched only at a period boundary.
// (R21) programmable dead time between one switch turning off and another on.
package hbd_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_NS = 25;
	localparam int PWM_HZ = 40_000;
	localparam int PERIOD_CYC = CLK_HZ / PWM_HZ;
	localparam int MIN_PULSE_NS = 1750;
	localparam int MIN_DUTY_CYC = (MIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 10;
	localparam int SMP_W = 12;

	// ****************************************
	// decay codes
	// ****************************************
	localparam logic [2:0] DK_SLOW_LS_DIODE = 3'h0;
	localparam logic [2:0] DK_SLOW_HS_DIODE = 3'h1;
	localparam logic [2:0] DK_SLOW_LS_FET = 3'h2;
	localparam logic [2:0] DK_SLOW_HS_FET = 3'h3;
	localparam logic [2:0] DK_FAST = 3'h4;
	localparam logic [2:0] DK_REVERSE = 3'h5;

	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_DUTY = 6'h04;
	localparam logic [5:0] OFS_TARGET = 6'h08;
	localparam logic [5:0] OFS_GAIN = 6'h0C;
	localparam logic [5:0] OFS_DEAD = 6'h10;
	localparam logic [5:0] OFS_STATUS = 6'h14;
	localparam logic [5:0] OFS_SMP_ACT = 6'h18;
	localparam logic [5:0] OFS_SMP_INACT = 6'h1C;
	localparam logic [5:0] OFS_CURRENT = 6'h20;
	// control fields
	localparam int CTRL_RUN = 0;
	localparam int CTRL_DIR_POS = 1;
	localparam int CTRL_ALT_EN = 2;
	localparam int CTRL_ZERO_FAST = 3;
	localparam int CTRL_BASE_LSB = 4;
	localparam int CTRL_ALT_LSB = 8;
	localparam int GAIN_SHIFT = 4;
	// reset values
	localparam logic [10:0] RST_CTRL = 11'h42A;
	localparam logic [CNT_W-1:0] RST_DUTY = 10'h000;
	localparam logic [7:0] RST_GAIN = 8'h10;
	localparam logic [7:0] RST_DEAD = 8'h04;
endpackage

// ===== core/hbd_drive.sv
// decay pattern generator, dead time, converter scheduling and current rebuild
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module hbd_drive (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic first_half_pos_drive,
	output logic first_half_neg_drive,
	output logic second_half_pos_drive,
	output logic second_half_neg_drive,
	output logic adc_trig,
	output logic adc_trig_active,
	input wire logic adc_valid,
	input wire logic signed [hbd_pkg::SMP_W-1:0] adc_data
);
	import hbd_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] duty_l;
		logic dir_l;
		logic run_l;
		logic [2:0] mode_l;
		logic forced_l;
		logic alt_l;
		logic [15:0] alt_cnt;
		logic [SMP_W-1:0] tgt_prev;
		logic [3:0] pat_cur;
		logic [7:0] dead_cnt;
		logic [3:0] out;
		logic trig;
		logic trig_act;
		logic tag_act;
		logic tag_dir;
		logic tag_slow;
		logic [SMP_W-1:0] smp_act;
		logic [SMP_W-1:0] smp_inact;
		logic signed [15:0] current;
		logic [10:0] ctrl;
		logic [CNT_W-1:0] duty;
		logic [SMP_W-1:0] target;
		logic [7:0] gain;
		logic [7:0] dead;
		logic ack;
		logic [31:0] rdata;
	} hbd_state_s;

	hbd_state_s st;
	hbd_state_s next_st;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic hbd_is_slow(input logic [2:0] m);
		hbd_is_slow = (m <= DK_SLOW_HS_FET);
	endfunction

	// pattern order {first pos, first neg, second pos, second neg}
	function automatic logic [3:0] hbd_pattern(input logic [2:0] m, input logic dp, input logic act);
		logic [3:0] p;
		p = 4'h0;
		if (act) begin
			p = dp ? 4'hA : 4'h5; // R11
		end else begin
			case (m)
				DK_SLOW_LS_DIODE: p = dp ? 4'h2 : 4'h4; // R2 R10
				DK_SLOW_HS_DIODE: p = dp ? 4'h8 : 4'h1; // R2 R10
				DK_SLOW_LS_FET: p = 4'h6; // R1 R12 R13
				DK_SLOW_HS_FET: p = 4'h9; // R2
				DK_REVERSE: p = dp ? 4'h5 : 4'hA; // R19
				default: p = 4'h0; // R19
			endcase
		end
		hbd_pattern = p;
	endfunction

	function automatic logic [CNT_W-1:0] hbd_clamp(input logic [CNT_W-1:0] d);
		hbd_clamp = d;
		if (d < CNT_W'(MIN_DUTY_CYC))
			hbd_clamp = CNT_W'(MIN_DUTY_CYC); // R16
		if (d > CNT_W'(PERIOD_CYC - MIN_DUTY_CYC))
			hbd_clamp = CNT_W'(PERIOD_CYC - MIN_DUTY_CYC);
	endfunction

	logic boundary;
	logic active_ph;
	logic [3:0] pat_want;
	logic [CNT_W-1:0] trig_act_at;
	logic [CNT_W-1:0] trig_inact_at;
	logic [SMP_W-1:0] drop;
	logic [15:0] alt_calc;
	logic [15:0] alt_now;
	logic zero_force;
	logic [SMP_W-1:0] smp_mag;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st = st;
		boundary = (st.cnt == CNT_W'(PERIOD_CYC - 1));
		active_ph = (st.cnt < st.duty_l);
		trig_act_at = st.duty_l >> 1;
		trig_inact_at = st.duty_l + ((CNT_W'(PERIOD_CYC) - st.duty_l) >> 1);
		drop = st.tgt_prev - st.target;
		alt_calc = 16'((20'(drop) * 20'(st.gain)) >> GAIN_SHIFT);
		zero_force = st.ctrl[CTRL_ZERO_FAST] && (st.target == '0);
		smp_mag = (adc_data < 0) ? SMP_W'(-adc_data) : SMP_W'(adc_data);
		alt_now = st.alt_cnt;

		// period counter and boundary latch, so no period mixes patterns
		next_st.cnt = boundary ? '0 : st.cnt + 1'b1;
		if (boundary) begin
			next_st.duty_l = hbd_clamp(st.duty); // R16 R20
			next_st.dir_l = st.ctrl[CTRL_DIR_POS]; // R20
			next_st.run_l = st.ctrl[CTRL_RUN];
			next_st.tgt_prev = st.target;
			if (st.target < st.tgt_prev)
				alt_now = alt_calc; // R8
			if (!st.ctrl[CTRL_ALT_EN])
				alt_now = 16'h0000; // R5
			next_st.alt_l = (alt_now != 16'h0000); // R6 R7
			next_st.alt_cnt = alt_now - 16'(next_st.alt_l); // R7
			next_st.forced_l = zero_force;
			if (zero_force)
				next_st.mode_l = DK_FAST; // R9
			else if (next_st.alt_l)
				next_st.mode_l = st.ctrl[CTRL_ALT_LSB +: 3]; // R6 R10
			else
				next_st.mode_l = st.ctrl[CTRL_BASE_LSB +: 3]; // R5 R3
		end

		// pattern with dead time: turn-offs act at once, turn-ons wait
		pat_want = st.run_l ? hbd_pattern(st.mode_l, st.dir_l, active_ph) : 4'h0;
		if (pat_want != st.pat_cur) begin
			next_st.pat_cur = pat_want;
			next_st.dead_cnt = st.dead; // R21
			next_st.out = st.out & pat_want;
		end else if (st.dead_cnt != 8'h00) begin
			next_st.dead_cnt = st.dead_cnt - 1'b1; // R21
			next_st.out = st.out & st.pat_cur;
		end else begin
			next_st.out = st.pat_cur;
		end

		// converter triggers at the middle of each pulse
		next_st.trig = 1'b0;
		if (st.run_l && (st.cnt == trig_act_at || st.cnt == trig_inact_at)) begin
			next_st.trig = 1'b1; // R14
			next_st.trig_act = (st.cnt == trig_act_at);
			next_st.tag_act = (st.cnt == trig_act_at);
			next_st.tag_dir = st.dir_l;
			next_st.tag_slow = (st.cnt != trig_act_at) && hbd_is_slow(st.mode_l);
		end

		// sample capture and current rebuild
		if (adc_valid && !st.tag_slow) begin // R4
			if (st.tag_act)
				next_st.smp_act = smp_mag; // R17
			else
				next_st.smp_inact = smp_mag; // R17 R18
			if (st.tag_act == st.tag_dir) begin // R15
				if (st.tag_dir)
					next_st.current = 16'(smp_mag);
				else
					next_st.current = -$signed(16'(smp_mag));
			end
		end

		// avalon slave: one wait state, then the answer
		next_st.ack = (avs_read || avs_write) && !st.ack;
		if ((avs_read || avs_write) && !st.ack) begin
			case (avs_address)
				OFS_CTRL: next_st.rdata = 32'(st.ctrl);
				OFS_DUTY: next_st.rdata = 32'(st.duty);
				OFS_TARGET: next_st.rdata = 32'(st.target);
				OFS_GAIN: next_st.rdata = 32'(st.gain);
				OFS_DEAD: next_st.rdata = 32'(st.dead);
				OFS_STATUS: next_st.rdata = {st.alt_cnt, 9'h000, st.run_l, st.dir_l, st.alt_l, st.forced_l, st.mode_l};
				OFS_SMP_ACT: next_st.rdata = 32'(st.smp_act);
				OFS_SMP_INACT: next_st.rdata = 32'(st.smp_inact);
				OFS_CURRENT: next_st.rdata = {{16{st.current[15]}}, st.current};
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
		if (st.ack && avs_write) begin
			case (avs_address)
				OFS_CTRL: begin
					if (avs_byteenable[0])
						next_st.ctrl[7:0] = avs_writedata[7:0];
					if (avs_byteenable[1])
						next_st.ctrl[10:8] = avs_writedata[10:8];
				end
				OFS_DUTY: begin
					if (avs_byteenable[0])
						next_st.duty[7:0] = avs_writedata[7:0];
					if (avs_byteenable[1])
						next_st.duty[9:8] = avs_writedata[9:8];
				end
				OFS_TARGET: begin
					if (avs_byteenable[0])
						next_st.target[7:0] = avs_writedata[7:0];
					if (avs_byteenable[1])
						next_st.target[11:8] = avs_writedata[11:8];
				end
				OFS_GAIN: begin
					if (avs_byteenable[0])
						next_st.gain = avs_writedata[7:0];
				end
				OFS_DEAD: begin
					if (avs_byteenable[0])
						next_st.dead = avs_writedata[7:0];
				end
				default: next_st.ctrl = next_st.ctrl; // read-only or unmapped: ignored
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
			st.duty_l <= CNT_W'(MIN_DUTY_CYC);
			st.dir_l <= 1'b1;
			st.mode_l <= DK_SLOW_LS_FET;
			st.ctrl <= RST_CTRL;
			st.duty <= RST_DUTY;
			st.gain <= RST_GAIN;
			st.dead <= RST_DEAD;
		end else begin
			st <= next_st;
		end
	end

	// outputs come straight from flops, waitrequest is the only gate
	assign first_half_pos_drive = st.out[3];
	assign first_half_neg_drive = st.out[2];
	assign second_half_pos_drive = st.out[1];
	assign second_half_neg_drive = st.out[0];
	assign adc_trig = st.trig;
	assign adc_trig_active = st.trig_act;
	assign avs_readdata = st.rdata;
	assign avs_waitrequest = (avs_read || avs_write) && !st.ack;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// triggers seen in the current period, helper for the two-per-period check
	logic [1:0] trig_seen;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			trig_seen <= 2'h0;
		else if (boundary)
			trig_seen <= 2'h0;
		else if (st.trig && trig_seen != 2'h3)
			trig_seen <= trig_seen + 2'h1;
	end

	a_duty_min_clamp: assert property (st.duty_l >= CNT_W'(MIN_DUTY_CYC)) // R16
		else $error("latched duty below minimum");
	a_slow_ls_pattern: assert property (st.run_l && st.mode_l == DK_SLOW_LS_FET && st.dir_l
		|-> pat_want == (active_ph ? 4'hA : 4'h6)) // R1
		else $error("low-side fet slow decay pattern wrong");
	a_ls_complement: assert property (st.run_l && st.mode_l == DK_SLOW_LS_FET && st.dir_l
		|-> pat_want[2] == !pat_want[3] && pat_want[1] == !pat_want[0]) // R12
		else $error("low-side fet outputs not complementary");
	a_fast_neg_zero: assert property (st.run_l && st.mode_l == DK_FAST |-> pat_want[2] == pat_want[0]
		&& (st.dir_l ? pat_want[2:0] ==? 3'b0?0 : 1'b1)) // R19
		else $error("fast decay drives a neg output while positive");
	a_two_triggers: assert property (boundary && st.run_l && $past(st.run_l, 300) |-> trig_seen == 2'h2) // R14
		else $error("trigger count per period not two");
	a_slow_sample_drop: assert property (adc_valid && st.tag_slow
		|=> $stable(st.smp_inact) && $stable(st.current)) // R4
		else $error("slow decay sample was used");
	a_zero_forces_fast: assert property (boundary && zero_force |=> st.mode_l == DK_FAST) // R9
		else $error("zero target did not force fast decay");
	a_fixed_uses_base: assert property (boundary && !st.ctrl[CTRL_ALT_EN] && !zero_force
		|=> st.mode_l == $past(st.ctrl[CTRL_BASE_LSB +: 3]) && st.alt_cnt == 16'h0000) // R5
		else $error("fixed decay left base decay");
	a_latch_boundary: assert property (!$past(boundary)
		|-> $stable(st.duty_l) && $stable(st.mode_l) && $stable(st.dir_l)) // R20
		else $error("drive settings changed inside a period");
	a_dead_gap: assert property ((st.out & ~$past(st.out)) != 4'h0 |-> $past(st.dead_cnt) == 8'h00) // R21
		else $error("output rose during dead time");
	a_recon_sign: assert property (adc_valid && !st.tag_slow && st.tag_act && st.tag_dir
		|=> st.current >= 0) // R15
		else $error("positive rebuild gave negative current");

	c_alt_period: cover property (boundary ##1 st.alt_l && st.mode_l == st.ctrl[CTRL_ALT_LSB +: 3]);
	c_zero_fast: cover property (st.forced_l && st.trig);
	c_neg_rebuild: cover property (adc_valid && !st.tag_act && !st.tag_dir && !st.tag_slow);
	c_bus_write: cover property (st.ack && avs_write && avs_address == OFS_DUTY);
endmodule // hbd_drive
`default_nettype wire

// ===== dv/hbd_adc_model.sv
// shunt converter model: answers each trigger after a set latency
`timescale 1ns/10ps
`default_nettype none
module hbd_adc_model (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic adc_trig,
	input wire logic adc_trig_active,
	input wire logic [3:0] lat,
	input wire logic signed [hbd_pkg::SMP_W-1:0] act_val,
	input wire logic signed [hbd_pkg::SMP_W-1:0] inact_val,
	output logic adc_valid,
	output logic signed [hbd_pkg::SMP_W-1:0] adc_data
);
	import hbd_pkg::*;
	logic [4:0] cnt;
	logic act_q;
	// one conversion per trigger, finished well before the next trigger
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt <= 5'h00;
			act_q <= 1'h0;
			adc_valid <= 1'h0;
			adc_data <= 12'h5A5;
		end else begin
			adc_valid <= 1'h0;
			adc_data <= ~adc_data; // data toggles outside a result, never a stale hold
			if (adc_trig) begin
				cnt <= {1'h0, lat} + 5'h01;
				act_q <= adc_trig_active;
			end else if (cnt != 5'h00) begin
				cnt <= cnt - 5'h01;
				if (cnt == 5'h01) begin
					adc_valid <= 1'h1;
					adc_data <= act_q ? act_val : inact_val;
				end
			end
		end
	end
endmodule // hbd_adc_model
`default_nettype wire

// ===== dv/hbd_bench.sv
// self-checking bench for the h-bridge decay drive
`timescale 1ns/10ps
`default_nettype none
module hbridge_decay_drive_and_current_sampling_bench;
	import hbd_pkg::*;
	logic clk_sys = 1'h0;
	logic resetn = 1'h0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] drv;
	logic adc_trig;
	logic adc_trig_active;
	logic adc_valid;
	logic signed [SMP_W-1:0] adc_data;
	logic signed [SMP_W-1:0] act_val = 12'h0;
	logic signed [SMP_W-1:0] inact_val = 12'h0;
	logic [3:0] lat = 4'h1;
	logic [31:0] q;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 64483;
	int dl[3] = '{20, MIN_DUTY_CYC, MIN_DUTY_CYC + 30};
	int w[3];
	int ov;
	int cur;
	int drop;
	int exp_q[$];

	always #12.5 clk_sys = ~clk_sys;

	hbd_drive i_dut (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .first_half_pos_drive(drv[3]), .first_half_neg_drive(drv[2]),
		.second_half_pos_drive(drv[1]), .second_half_neg_drive(drv[0]), .adc_trig, .adc_trig_active,
		.adc_valid, .adc_data);
	hbd_adc_model i_adc (.clk_sys, .resetn, .adc_trig, .adc_trig_active, .lat, .act_val, .inact_val,
		.adc_valid, .adc_data);

	// *****
	// helpers
	// *****
	// inactive pattern {1pos,1neg,2pos,2neg} per decay code and direction
	function automatic logic [3:0] inact_pat(int code, bit pos);
		case (code)
			0: return pos ? 4'h2 : 4'h4;
			1: return pos ? 4'h8 : 4'h1;
			2: return 4'h6;
			3: return 4'h9;
			5: return pos ? 4'h5 : 4'hA;
			default: return 4'h0;
		endcase
	endfunction
	function automatic logic [31:0] cw(bit dir, bit alt, logic [2:0] base, logic [2:0] altd);
		return {21'h0, altd, 1'h0, base, 1'h1, alt, dir, 1'h1};
	endfunction
	// request held until waitrequest is seen low at a rising edge; data taken at that edge
	task automatic bus(bit wr, logic [5:0] a, logic [31:0] d);
		logic wt;
		wt = 1'h1;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'h3;
		avs_read <= !wr;
		avs_write <= wr;
		while (wt) begin
			@(posedge clk_sys);
			wt = avs_waitrequest;
			q = avs_readdata;
		end
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	// outputs looked at on the falling edge, where they have settled
	task automatic trig(bit act);
		do @(negedge clk_sys); while (!(adc_trig === 1'h1 && adc_trig_active === act));
	endtask
	task automatic pw(output int n, output int o);
		n = 0;
		o = 0;
		trig(1);
		repeat (PERIOD_CYC) begin
			@(negedge clk_sys);
			n += int'(drv[3]);
			o += int'(drv[3] & drv[2]);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// bounded run, a hang is counted as a mismatch
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			conclude();
		end
	end

	// *****
	// scenarios
	// *****
	initial begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'h1;
		bus(0, OFS_CTRL, 32'h0);
		chk("ctrl", 32'(RST_CTRL), q);
		bus(0, OFS_GAIN, 32'h0);
		chk("gain", 32'(RST_GAIN), q);
		bus(1, 6'h24, 32'hFFFF);
		bus(0, 6'h24, 32'h0);
		chk("unmapped", 32'h0, q);
		chk("idle", 32'h0, 32'(drv));
		$display("test registers done");
		// every decay code in both directions
		bus(1, OFS_TARGET, 32'h64);
		bus(1, OFS_DUTY, 32'h64);
		for (int c = 0; c < 6; c++)
			for (int d = 0; d < 2; d++) begin
				bus(1, OFS_CTRL, cw(d, 0, 3'(c), 3'h4));
				trig(1);
				chk("active", d ? 32'hA : 32'h5, 32'(drv));
				trig(0);
				chk("inactive", 32'(inact_pat(c, d)), 32'(drv));
			end
		$display("test patterns done");
		// short duties raised to the minimum, first pair never overlaps
		for (int j = 0; j < 3; j++) begin
			bus(1, OFS_DUTY, 32'(dl[j]));
			pw(w[j], ov);
			pw(w[j], ov);
			chk("overlap", 32'h0, 32'(ov));
		end
		chk("clamp", 32'(w[1]), 32'(w[0]));
		chk("width", 32'(w[1] + 30), 32'(w[2]));
		$display("test duty done");
		// zero gain keeps this drop from leaving alternate periods behind
		bus(1, OFS_GAIN, 32'h0);
		bus(1, OFS_TARGET, 32'h0);
		trig(0);
		trig(0);
		chk("zero", 32'h0, 32'(drv));
		bus(0, OFS_STATUS, 32'h0);
		chk("forced", 32'h1, 32'(q[3]));
		$display("test zero target done");
		// fixed decay, then alternate fast, then alternate diode slow
		bus(1, OFS_GAIN, 32'h20);
		for (int a = 0; a < 3; a++) begin
			bus(1, OFS_TARGET, 32'h64);
			bus(1, OFS_CTRL, cw(1, a > 0, 3'h2, a == 2 ? 3'h0 : 3'h4));
			trig(0);
			trig(0);
			drop = 1 + $unsigned($random(seed)) % 3;
			bus(1, OFS_TARGET, 32'(100 - drop));
			for (int k = 0; k < 7; k++)
				exp_q.push_back(k < (a > 0 ? (drop * 32) >> GAIN_SHIFT : 0) ? inact_pat(a == 2 ? 0 : 4, 1) : 6);
			for (int k = 0; k < 7; k++) begin
				trig(0);
				chk("decay", 32'(exp_q.pop_front()), 32'(drv));
			end
		end
		$display("test alternate done");
		// current rebuilt from the sample that matches the direction
		bus(1, OFS_TARGET, 32'h64);
		for (int d = 0; d < 2; d++)
			for (int b = 0; b < 2; b++) begin
				bus(1, OFS_CTRL, cw(d, 0, b ? 3'h2 : 3'h4, 3'h4));
				trig(1);
				@(posedge clk_sys);
				act_val <= 12'(1 + $unsigned($random(seed)) % 1000);
				inact_val <= 12'(-1 - $unsigned($random(seed)) % 1000);
				lat <= 4'($unsigned($random(seed)) % 8);
				trig(0);
				trig(1);
				if (d)
					cur = int'(act_val);
				else if (!b)
					cur = int'(inact_val);
				bus(0, OFS_CURRENT, 32'h0);
				chk("current", 32'(cur), q);
				bus(0, OFS_SMP_ACT, 32'h0);
				chk("act_mag", 32'(int'(act_val)), q);
			end
		$display("test current done");
		conclude();
	end
endmodule // hbridge_decay_drive_and_current_sampling_bench
`default_nettype wire
